//--- pkg/erxdma_pkg.sv
package erxdma_pkg;

   // =====================================================================
   // register map: word indices, byte address is four times the index
   // =====================================================================
   localparam int          ADDR_W          = 14;
   localparam int          IDX_W           = 12;
   localparam logic [11:0] IDX_RX_CONFIG   = 12'h003;
   localparam logic [11:0] IDX_RX_EVENT    = 12'h004;
   localparam logic [11:0] IDX_BUF_CONFIG  = 12'h00B;
   localparam logic [11:0] IDX_BUF_EVENT   = 12'h00C;
   localparam logic [11:0] IDX_MISSED      = 12'h010;
   localparam logic [11:0] IDX_BUS_CONTROL = 12'h017;
   localparam logic [11:0] IDX_CHAN_SEL    = 12'h024;
   localparam logic [11:0] IDX_FRAME_START = 12'h026;
   localparam logic [11:0] IDX_FRAMES      = 12'h028;
   localparam logic [11:0] IDX_BYTES       = 12'h02A;
   localparam logic [11:0] IDX_RX_STATUS   = 12'h400;
   localparam logic [11:0] IDX_RX_LENGTH   = 12'h402;

   // =====================================================================
   // field positions and reset values
   // =====================================================================
   localparam int          CFG_STREAM_BIT    = 7;
   localparam int          CFG_DMA_ONLY_BIT  = 9;
   localparam int          CFG_AUTO_DMA_BIT  = 10;
   localparam int          BUFFER_CONFIG_REG_IRQ_EN_BIT = 7;
   localparam int          BUFEV_FLAG_BIT    = 7;
   localparam int          BUS_CONTROL_REG_RESET_BIT  = 6;
   localparam int          BUS_CONTROL_REG_BURST_BIT  = 11;
   localparam int          BUS_CONTROL_REG_SIZE_BIT   = 13;
   localparam int          FRAMES_W          = 12;
   localparam int          NUM_CHAN          = 3;
   localparam logic [1:0]  CHAN_MAX          = 2'h2;
   localparam logic [15:0] REG_RESET         = 16'h0000;
   localparam logic [15:0] MASK_16K          = 16'h3FFF;
   localparam logic [15:0] MASK_64K          = 16'hFFFF;
   localparam logic [16:0] HDR_ROUND         = 17'h00007;
   localparam logic [16:0] ALIGN_MASK        = 17'h1FFFC;
   localparam logic [16:0] HDR_BYTES         = 17'h00004;

   // =====================================================================
   // timing
   // =====================================================================
   localparam int          CLK_MHZ        = 40;
   localparam int          BURST_ON_NS    = 28000;
   localparam int          BURST_OFF_NS   = 1300;
   localparam int          BURST_ON_CYC   = BURST_ON_NS * CLK_MHZ / 1000;
   localparam int          BURST_OFF_CYC  = (BURST_OFF_NS * CLK_MHZ + 999)
                                            / 1000;
   localparam logic [10:0] BURST_ON_LAST  = 11'(BURST_ON_CYC - 1);
   localparam logic [10:0] BURST_OFF_LAST = 11'(BURST_OFF_CYC - 1);

   // =====================================================================
   // types
   // =====================================================================
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_XFER = 2'h1,
      ST_DONE = 2'h3,
      ST_GAP  = 2'h2
   } erxdma_state_type;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
      logic              wr;
      logic              rd;
   } erxdma_bus_req_type;

   typedef struct packed
   {
      logic [15:0] status;
      logic [15:0] length;
   } erxdma_frame_desc_type;

endpackage

//--- design/erxdma_engine.sv
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module erxdma_engine
   import erxdma_pkg::*;
(
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst_n,
   input  wire erxdma_bus_req_type    i_bus,
   output logic [15:0]                o_rdata,
   input  wire logic                  i_frame_ready,
   input  wire erxdma_frame_desc_type i_frame,
   input  wire logic [15:0]           i_frame_data,
   output logic                       o_frame_take,
   output logic                       o_frame_release,
   input  wire logic                  i_frame_missed,
   input  wire logic                  i_stream_cycle_end,
   input  wire logic [15:0]           i_rx_event,
   output logic [NUM_CHAN-1:0]        o_dma_request,
   input  wire logic [NUM_CHAN-1:0]   i_dma_ack_n,
   output logic [15:0]                o_dma_data,
   output logic                       o_dma_data_valid,
   output logic [15:0]                o_dma_offset,
   output logic                       o_irq
);

   // =====================================================================
   // state and registers
   // =====================================================================
   erxdma_state_type    state;
   erxdma_state_type    next_state;
   logic [15:0]         rx_config;
   logic [15:0]         buf_config;
   logic [15:0]         bus_control;
   logic [1:0]          chan_sel;
   logic [15:0]         frame_start;
   logic [FRAMES_W-1:0] frames_moved;
   logic [15:0]         bytes_moved;
   logic [15:0]         missed;
   logic                flag;
   logic [15:0]         rx_status_q;
   logic [15:0]         rx_len_q;
   logic [15:0]         wr_ptr;
   logic [15:0]         word_idx;
   logic [15:0]         last_idx;
   logic [15:0]         free_base;
   logic [15:0]         commit_end;
   logic                committed;
   logic [10:0]         burst_cnt;

   logic [IDX_W-1:0]    idx;
   logic                aligned;
   logic                wr_en;
   logic                rd_en;
   logic                rd_frames;
   logic                rd_bytes;
   logic                rd_missed;
   logic                rd_bufev;
   logic                dma_reset;
   logic                dma_mode;
   logic                stream;
   logic [15:0]         buf_mask;
   logic [15:0]         need_in;
   logic [15:0]         need_q;
   logic [15:0]         room;
   logic                space_ok;
   logic                ack;
   logic                take;
   logic                last_take;
   logic                frame_done;
   logic [15:0]         rd_value;

   function automatic logic [15:0] fn_need(input logic [15:0] len);
      fn_need = 16'((({1'b0, len} + HDR_ROUND) & ALIGN_MASK));
   endfunction

   // =====================================================================
   // decode
   // =====================================================================
   assign idx       = i_bus.addr[ADDR_W-1:2];
   assign aligned   = (i_bus.addr[1:0] == 2'h0);
   assign wr_en     = i_bus.wr && aligned;
   assign rd_en     = i_bus.rd && aligned;
   assign rd_frames = rd_en && (idx == IDX_FRAMES);
   assign rd_bytes  = rd_en && (idx == IDX_BYTES);
   assign rd_missed = rd_en && (idx == IDX_MISSED);
   assign rd_bufev  = rd_en && (idx == IDX_BUF_EVENT);
   assign dma_reset = wr_en && (idx == IDX_BUS_CONTROL)
                      && i_bus.wdata[BUS_CONTROL_REG_RESET_BIT];
   // dma-only wins
   // auto-switch alone is not served here, so only the dma-only bit counts
   assign dma_mode  = rx_config[CFG_DMA_ONLY_BIT];
   assign stream    = rx_config[CFG_STREAM_BIT];
   assign buf_mask  = bus_control[BUS_CONTROL_REG_SIZE_BIT] ? MASK_64K : MASK_16K;
   assign need_in   = fn_need(i_frame.length);
   assign need_q    = fn_need(rx_len_q);
   assign room      = (free_base - wr_ptr) & buf_mask;
   assign space_ok  = !committed || (need_in <= room);
   assign ack       = !i_dma_ack_n[chan_sel];
   assign take      = (state == ST_XFER) && o_dma_data_valid && ack
                      && o_dma_request[chan_sel];
   assign last_take = take && (word_idx == last_idx);
   assign frame_done = (state == ST_DONE);

   // =====================================================================
   // transfer sequencer
   // =====================================================================
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            // whole frame ready
            // ready may still stand while the old release pulse does
            if (dma_mode && i_frame_ready && space_ok && !o_frame_release)
               next_state = ST_XFER;
         ST_XFER:
            if (last_take)
               next_state = ST_DONE;
            else if (bus_control[BUS_CONTROL_REG_BURST_BIT]
                     && burst_cnt == BURST_ON_LAST)
               next_state = ST_GAP;
         ST_GAP:
            if (burst_cnt == BURST_OFF_LAST)
               next_state = ST_XFER;
         ST_DONE:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         burst_cnt <= 11'h000;
      else if (next_state != state)
         burst_cnt <= 11'h000;
      else
         burst_cnt <= burst_cnt + 11'h001;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_dma_request <= 3'h0;
      else if (next_state == ST_XFER)
         o_dma_request <= 3'(3'h1 << chan_sel);
      else
         o_dma_request <= 3'h0;
   end

   // =====================================================================
   // word path
   // =====================================================================
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_status_q      <= REG_RESET;
         rx_len_q         <= REG_RESET;
         last_idx         <= REG_RESET;
         word_idx         <= REG_RESET;
         o_dma_offset     <= REG_RESET;
         o_dma_data       <= REG_RESET;
         o_dma_data_valid <= 1'b0;
         o_frame_take     <= 1'b0;
      end
      else if (state == ST_IDLE && next_state == ST_XFER)
      begin
         rx_status_q      <= i_frame.status;
         rx_len_q         <= i_frame.length;
         last_idx         <= 16'((({1'b0, i_frame.length} + 17'h00001)
                                  >> 1) + 17'h00001);
         word_idx         <= REG_RESET;
         o_dma_offset     <= wr_ptr;
         o_dma_data_valid <= 1'b0;
         o_frame_take     <= 1'b0;
      end
      else if (take)
      begin
         o_dma_data_valid <= 1'b0;
         word_idx         <= word_idx + 16'h0001;
         o_dma_offset     <= (o_dma_offset + 16'h0002) & buf_mask;
         o_frame_take     <= (word_idx >= 16'h0002);
      end
      else
      begin
         o_frame_take <= 1'b0;
         // one idle cycle after a take lets on-chip memory advance
         if ((state == ST_XFER || state == ST_GAP) && !o_dma_data_valid
             && !o_frame_take && word_idx <= last_idx)
         begin
            o_dma_data_valid <= 1'b1;
            case (word_idx)
               16'h0000: o_dma_data <= rx_status_q;
               16'h0001: o_dma_data <= rx_len_q;
               default:  o_dma_data <= i_frame_data;
            endcase
         end
      end
   end

   // =====================================================================
   // host ring bookkeeping
   // =====================================================================
   // frame end update
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr          <= REG_RESET;
         frame_start     <= REG_RESET;
         o_frame_release <= 1'b0;
      end
      else
      begin
         o_frame_release <= frame_done;
         if (frame_done)
         begin
            frame_start <= wr_ptr;
            wr_ptr      <= (wr_ptr + need_q) & buf_mask;
         end
         else if (dma_reset && state == ST_IDLE)
            wr_ptr <= REG_RESET;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         free_base  <= REG_RESET;
         commit_end <= REG_RESET;
         committed  <= 1'b0;
      end
      else if (dma_reset)
      begin
         free_base <= REG_RESET;
         committed <= 1'b0;
      end
      else if (rd_frames)
      begin
         if (committed)
            free_base <= commit_end;
         committed  <= (frames_moved != 12'h000);
         commit_end <= wr_ptr;
      end
      else if (rd_bufev && flag && committed && frames_moved != 12'h000)
      begin
         free_base <= commit_end;
         committed <= 1'b0;
      end
   end

   // =====================================================================
   // counters and flag
   // =====================================================================
   // set beats read clear
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         frames_moved <= 12'h000;
         bytes_moved  <= REG_RESET;
      end
      else
      begin
         if (frame_done)
            frames_moved <= (rd_frames ? 12'h000 : frames_moved) + 12'h001;
         else if (rd_frames)
            frames_moved <= 12'h000;
         if (frame_done)
            bytes_moved <= (rd_bytes ? REG_RESET : bytes_moved)
                           + rx_len_q + 16'(HDR_BYTES);
         else if (rd_bytes)
            bytes_moved <= REG_RESET;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         missed <= REG_RESET;
      else if (i_frame_missed)
         missed <= (rd_missed ? REG_RESET : missed) + 16'h0001;
      else if (rd_missed)
         missed <= REG_RESET;
   end

   // flag set clear
   // reading the event register never touches it
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         flag <= 1'b0;
      else if (stream ? i_stream_cycle_end : frame_done)
         flag <= 1'b1;
      else if (frames_moved == 12'h000)
         flag <= 1'b0;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_irq <= 1'b0;
      else
         o_irq <= flag && buf_config[BUFFER_CONFIG_REG_IRQ_EN_BIT];
   end

   // =====================================================================
   // register port
   // =====================================================================
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_config   <= REG_RESET;
         buf_config  <= REG_RESET;
         bus_control <= REG_RESET;
         chan_sel    <= 2'h0;
      end
      else if (wr_en)
      begin
         case (idx)
            IDX_RX_CONFIG:   rx_config  <= i_bus.wdata;
            IDX_BUF_CONFIG:  buf_config <= i_bus.wdata;
            // reset bit acts once and is not stored
            IDX_BUS_CONTROL:
               bus_control <= i_bus.wdata & ~(16'h0001 << BUS_CONTROL_REG_RESET_BIT);
            IDX_CHAN_SEL:
               if (i_bus.wdata[1:0] <= CHAN_MAX && i_bus.wdata[15:2] == 14'h0)
                  chan_sel <= i_bus.wdata[1:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      case (idx)
         IDX_RX_CONFIG:   rd_value = rx_config;
         IDX_RX_EVENT:    rd_value = dma_mode ? REG_RESET : i_rx_event;
         IDX_BUF_CONFIG:  rd_value = buf_config;
         IDX_BUF_EVENT:   rd_value = 16'(flag) << BUFEV_FLAG_BIT;
         IDX_MISSED:      rd_value = missed;
         IDX_BUS_CONTROL: rd_value = bus_control;
         IDX_CHAN_SEL:    rd_value = {14'h0000, chan_sel};
         IDX_FRAME_START: rd_value = frame_start;
         IDX_FRAMES:      rd_value = {4'h0, frames_moved};
         IDX_BYTES:       rd_value = bytes_moved;
         IDX_RX_STATUS:   rd_value = rx_status_q;
         IDX_RX_LENGTH:   rd_value = rx_len_q;
         default:         rd_value = REG_RESET;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= REG_RESET;
      else if (rd_en)
         o_rdata <= rd_value;
      else
         o_rdata <= REG_RESET;
   end

   // =====================================================================
   // checks
   // =====================================================================
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   AST_REQ_NEEDS_FRAME: assert property (
      $rose(|o_dma_request) && $past(state) == ST_IDLE
      |-> $past(i_frame_ready && rx_config[CFG_DMA_ONLY_BIT]))
      else $error("request raised without a ready frame in dma mode");
   AST_ONE_CHANNEL: assert property (
      |o_dma_request |-> o_dma_request == 3'(3'h1 << chan_sel)
                         && chan_sel <= CHAN_MAX)
      else $error("request on wrong pin");
   AST_STATUS_FIRST: assert property (
      state == ST_XFER && word_idx == 16'h0000 && o_dma_data_valid
      |-> o_dma_data == rx_status_q)
      else $error("first word is not the status");
   AST_LENGTH_SECOND: assert property (
      take && word_idx == 16'h0000
      |-> ##[1:3] o_dma_data_valid && o_dma_data == rx_len_q)
      else $error("second word is not the length");
   AST_BURST_ON_TIME: assert property (
      state == ST_GAP && $past(state) == ST_XFER
      |-> $past(burst_cnt) == BURST_ON_LAST
          && $past(bus_control[BUS_CONTROL_REG_BURST_BIT]))
      else $error("burst window length wrong");
   AST_BURST_OFF_TIME: assert property (
      $past(state) == ST_GAP && state == ST_XFER
      |-> $past(burst_cnt) == BURST_OFF_LAST && $past(o_dma_request) == 3'h0
          && |o_dma_request)
      else $error("burst gap length wrong");
   AST_COUNT_ON_DONE: assert property (
      frame_done && !rd_frames
      |=> frames_moved == $past(frames_moved) + 12'h001 && o_frame_release
          && frame_start == $past(wr_ptr))
      else $error("frame end did not update counters");
   AST_FLAG_SETS: assert property (
      frame_done && !stream |=> flag ##1 flag)
      else $error("flag not set after frame");
   AST_FLAG_CLEARS: assert property (
      frames_moved == 12'h000 && !frame_done && !i_stream_cycle_end
      |=> !flag)
      else $error("flag held with zero count");
   AST_IRQ_FOLLOWS: assert property (
      flag && buf_config[BUFFER_CONFIG_REG_IRQ_EN_BIT] |=> o_irq)
      else $error("interrupt missing");
   AST_EVENT_ZERO: assert property (
      rd_en && idx == IDX_RX_EVENT && dma_mode |=> o_rdata == 16'h0000)
      else $error("receive event not zero in dma mode");
   AST_MISSED_COUNTS: assert property (
      i_frame_missed && !rd_missed |=> missed == $past(missed) + 16'h0001)
      else $error("missed frame not counted");
   AST_RING_ALIGNED: assert property (
      wr_ptr[1:0] == 2'h0 && frame_start[1:0] == 2'h0)
      else $error("frame start not on 32-bit boundary");
   AST_COMMIT_KEPT: assert property (
      state == ST_IDLE && next_state == ST_XFER && committed
      |-> need_in <= room)
      else $error("frame would overwrite committed space");

   COV_FRAME: cover property (frame_done);
   COV_BURST_GAP: cover property (state == ST_GAP ##1 state == ST_XFER);
   COV_COMMIT_FREE: cover property (committed ##[1:1000] !committed);
   COV_SET_CLEAR: cover property (frame_done && rd_frames);

endmodule

`default_nettype wire

//--- tb/erxdma_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// host dma controller, prompt or slow
module erxdma_host
   import erxdma_pkg::*;
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_n,
   input  wire logic [NUM_CHAN-1:0] i_req,
   input  wire logic                i_slow,
   output logic [NUM_CHAN-1:0]      o_ack_n
);
   logic tick;
   // ring base is kept by the host; model deals in offsets only
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
      if (!i_rst_n)
         {tick, o_ack_n} <= {1'b0, {NUM_CHAN{1'b1}}};
      else
         {tick, o_ack_n} <= {~tick, ~(i_req & {NUM_CHAN{~i_slow | tick}})};
endmodule
`default_nettype wire

//--- tb/tb_erxdma_engine.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// bench: registers, three frames, missed count
module tb_erxdma_engine
   import erxdma_pkg::*;
;
   logic                  clk = 1'b0, rst_n = 1'b0, rdy = 1'b0;
   logic                  miss = 1'b0, slow = 1'b0;
   logic                  take, rel, vld, irq;
   logic [15:0]           dw = 16'hA000, rdata, odata, offs;
   logic [NUM_CHAN-1:0]   req, ack_n;
   logic [NUM_CHAN-1:0]   seen = '0;
   erxdma_bus_req_type    b = '0;
   erxdma_frame_desc_type fr = '0;
   logic [15:0]           w[$], o[$];
   int                    fails = 0, n_checks = 0, cyc = 0;
   int                    rises = 0, hi = 0, lo = 0;
   logic                  pr = 1'b0;

   always #12.5 clk = ~clk;

   erxdma_engine u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus(b),
      .o_rdata(rdata), .i_frame_ready(rdy), .i_frame(fr),
      .i_frame_data(dw), .o_frame_take(take), .o_frame_release(rel),
      .i_frame_missed(miss), .i_stream_cycle_end(1'b0),
      .i_rx_event(16'h1234), .o_dma_request(req), .i_dma_ack_n(ack_n),
      .o_dma_data(odata), .o_dma_data_valid(vld), .o_dma_offset(offs),
      .o_irq(irq));
   erxdma_host u_host (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req),
      .i_slow(slow), .o_ack_n(ack_n));

   // words as the host really takes them
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      seen <= seen | req;
      // request windows as the host sees them
      pr <= |req;
      if (|req && !pr)
         rises <= rises + 1;
      if (|req && lo == 0)
         hi <= hi + 1;
      if (rdy && !(|req) && rises == 1)
         lo <= lo + 1;
      if (take)
         dw <= dw + 16'h0001;
      if (vld && |(req & ~ack_n))
      begin
         w.push_back(odata);
         o.push_back(offs);
      end
      if (cyc == 20000)
      begin
         fails++;
         test_done();
      end
   end

   task automatic bus(input logic wr, input logic [11:0] i,
                      input logic [15:0] d);
      @(posedge clk);
      b <= {i, 2'b00, d, wr, ~wr};
      @(posedge clk);
      b.wr <= 1'b0;
      b.rd <= 1'b0;
      #1;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, g);
      end
   endtask

   task automatic rd(input logic [11:0] i, input logic [15:0] m,
                     input logic [15:0] e, input string n);
      bus(1'b0, i, 16'h0000);
      chk(n, e, rdata & m);
   endtask

   task automatic frame(input logic [15:0] len);
      w.delete();
      o.delete();
      seen = '0;
      @(posedge clk);
      fr <= {16'h5A00 | len, len};
      rdy <= 1'b1;
      for (int t = 0; t < 2000 && rel !== 1'b1; t++)
         @(posedge clk) #1;
      @(posedge clk);
      rdy <= 1'b0;
      #1;
   endtask

   task automatic t_regs();
      rd(IDX_FRAMES, 16'hFFFF, 16'h0000, "frames0");
      rd(IDX_RX_EVENT, 16'hFFFF, 16'h1234, "event0");
      rd(12'h0FF, 16'hFFFF, 16'h0000, "unmapped");
      bus(1'b1, IDX_CHAN_SEL, 16'h0003);
      rd(IDX_CHAN_SEL, 16'h0003, 16'h0000, "chan3");
      repeat (2)
      begin
         @(posedge clk);
         miss <= 1'b1;
         @(posedge clk);
         miss <= 1'b0;
      end
      rd(IDX_MISSED, 16'hFFFF, 16'h0002, "missed");
   endtask

   task automatic t_one();
      logic [15:0] d0;
      d0 = dw;
      bus(1'b1, IDX_BUF_CONFIG, 16'h0080);
      bus(1'b1, IDX_RX_CONFIG, 16'h0600);
      chk("idle req", 16'h0000, {13'h0000, req});
      frame(16'h0005);
      chk("words", 16'h0005, 16'(w.size()));
      chk("status", 16'h5A05, w[0]);
      chk("length", 16'h0005, w[1]);
      chk("data", d0, w[2]);
      rd(IDX_BUF_EVENT, 16'h0080, 16'h0080, "flag");
      chk("irq", 16'h0001, {15'h0000, irq});
      rd(IDX_RX_EVENT, 16'hFFFF, 16'h0000, "event");
      rd(IDX_FRAME_START, 16'hFFFF, 16'h0000, "start");
      rd(IDX_BYTES, 16'hFFFF, 16'h0009, "bytes");
      rd(IDX_FRAMES, 16'h0FFF, 16'h0001, "frames");
      rd(IDX_FRAMES, 16'h0FFF, 16'h0000, "reread");
      rd(IDX_BUF_EVENT, 16'h0080, 16'h0000, "flag clr");
   endtask

   task automatic t_two();
      bus(1'b1, IDX_CHAN_SEL, 16'h0001);
      slow <= 1'b1;
      frame(16'h0008);
      slow <= 1'b0;
      chk("chan", 16'h0002, {13'h0000, seen});
      chk("offset", 16'h000C, o[0]);
      chk("last off", 16'h0016, o[5]);
      rd(IDX_FRAME_START, 16'hFFFF, 16'h000C, "start2");
      rd(IDX_BYTES, 16'hFFFF, 16'h000C, "bytes2");
   endtask

   task automatic t_burst();
      bus(1'b1, IDX_BUS_CONTROL, 16'h0840);
      rises = 0;
      hi = 0;
      lo = 0;
      frame(16'h0400);
      chk("burst words", 16'h0202, 16'(w.size()));
      chk("rises", 16'h0002, 16'(rises));
      chk("on cycles", 16'(BURST_ON_CYC), 16'(hi));
      chk("off cycles", 16'(BURST_OFF_CYC), 16'(lo));
      chk("reset off", 16'h0000, o[0]);
      rd(IDX_BUS_CONTROL, 16'hFFFF, 16'h0800, "bus_control_reg");
      rd(IDX_FRAME_START, 16'hFFFF, 16'h0000, "start3");
      rd(IDX_FRAMES, 16'h0FFF, 16'h0002, "frames2");
      rd(IDX_BYTES, 16'hFFFF, 16'h0404, "bytes3");
   endtask

   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_one();
      t_two();
      t_burst();
      test_done();
   end
endmodule
`default_nettype wire
